// ==== servo_status_regs.vh ====
// Register offsets, field positions, selector codes and timing counts of the servo status output selector.
`ifndef SERVO_STATUS_REGS_VH
`define SERVO_STATUS_REGS_VH

// Register byte addresses.
`define REG_CTRL         8'h00
`define REG_OL_TIME      8'h04
`define REG_WARN_PCT     8'h08
`define REG_STATUS       8'h0c
`define REG_IRQ_STATUS   8'h10
`define REG_IRQ_MASK     8'h14
`define REG_OL_ACC       8'h18

// Selector codes.
`define SEL_SERVO_FAULT  8'h07
`define SEL_OL_WARN      8'h10
`define SEL_WARN         8'h11
`define SEL_OVF          8'h12
`define SEL_REV_LIMIT    8'h13
`define SEL_FWD_LIMIT    8'h14
`define SEL_CMD_DONE     8'h15

// Status bit positions (shared by live status, sticky status and mask).
`define ST_OL_WARN       0
`define ST_OL_FAULT      1
`define ST_SERVO_FAULT   2
`define ST_WARN          3
`define ST_OVF           4
`define ST_REV_LIMIT     5
`define ST_FWD_LIMIT     6
`define ST_CMD_DONE      7
`define ST_WIDTH         8

// Reset values.
`define RST_SEL          8'h07
`define RST_WARN_PCT     8'h3c
// Overload time counted in milliseconds; 8000 ms default.
`define RST_OL_TIME_MS   32'h00001f40
`define MS_NS            1000000
`define CLK_PERIOD_NS    10
`define TICK_CYCLES      (`MS_NS / `CLK_PERIOD_NS)

`endif

// ==== servo_status_output_selector.v ====
// Servo status output selector with overload timing and a Wishbone register slave.
`timescale 1ns/1ns
`default_nettype none
`include "servo_status_regs.vh"

module servo_status_output_selector #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter NUM_OUT     = 4
) (
    // Clock and reset.
    input  wire                  clk_i,
    input  wire                  rst_i,
    // Wishbone slave.
    input  wire                  cyc_i,
    input  wire                  stb_i,
    input  wire                  we_i,
    input  wire [7:0]            adr_i,
    input  wire [3:0]            sel_i,
    input  wire [31:0]           dat_i,
    output reg  [31:0]           dat_o,
    output reg                   ack_o,
    // Drive conditions.
    input  wire                  overload_i,
    input  wire                  fault_i,
    input  wire                  rev_limit_err_i,
    input  wire                  fwd_limit_err_i,
    input  wire                  estop_i,
    input  wire                  comm_err_i,
    input  wire                  undervolt_i,
    input  wire                  poscmd_overflow_i,
    input  wire                  rev_soft_limit_i,
    input  wire                  fwd_soft_limit_i,
    input  wire                  pr_cmd_busy_i,
    input  wire                  pr_cmd_started_i,
    // Status outputs.
    output reg  [NUM_OUT-1:0]    dig_out_o,
    output reg                   overload_fault_alarm_o,
    output reg                   irq_o
);

    reg  [8*NUM_OUT-1:0]       out_sel;
    reg  [31:0]                ol_time_ms;
    reg  [7:0]                 warn_pct;
    reg  [`ST_WIDTH-1:0]       irq_status;
    reg  [`ST_WIDTH-1:0]       irq_mask;
    reg  [31:0]                ol_acc_ms;
    reg  [31:0]                tick_cnt;
    reg                        overload_warn_out;
    reg                        overload_fault_alarm;
    reg                        cmd_done;
    reg                        cmd_seen;
    reg  [`ST_WIDTH-1:0]       live_prev;
    reg  [31:0]                next_dat;
    wire [39:0]                warn_product;
    wire [39:0]                warn_quot;
    wire [31:0]                warn_time_threshold;
    wire [`ST_WIDTH-1:0]       live;
    wire                       servo_fault_out;
    wire                       general_warn;
    wire                       wb_req;
    wire [`ST_WIDTH-1:0]       rise;

    // Threshold in ms: overload time times percent over one hundred.
    assign warn_product        = ol_time_ms * warn_pct;
    // Divide the full product so that long overload times do not wrap before scaling.
    assign warn_quot           = warn_product / 40'd100;
    assign warn_time_threshold = warn_quot[31:0];

    assign general_warn    = rev_limit_err_i | fwd_limit_err_i | estop_i | comm_err_i | undervolt_i;
    assign servo_fault_out = fault_i | overload_fault_alarm;

    assign live[`ST_OL_WARN]     = overload_warn_out;
    assign live[`ST_OL_FAULT]    = overload_fault_alarm;
    assign live[`ST_SERVO_FAULT] = servo_fault_out;
    assign live[`ST_WARN]        = general_warn;
    assign live[`ST_OVF]         = poscmd_overflow_i;
    assign live[`ST_REV_LIMIT]   = rev_soft_limit_i;
    assign live[`ST_FWD_LIMIT]   = fwd_soft_limit_i;
    assign live[`ST_CMD_DONE]    = cmd_done;

    assign rise   = live & ~live_prev;
    assign wb_req = cyc_i & stb_i & ~ack_o;

    // Maps a selector code onto the live condition it names; unknown codes give low.
    function sel_level;
        input [7:0]            code;
        input [`ST_WIDTH-1:0]  st;
        begin
            case (code)
                `SEL_SERVO_FAULT: sel_level = st[`ST_SERVO_FAULT];
                `SEL_OL_WARN:     sel_level = st[`ST_OL_WARN];
                `SEL_WARN:        sel_level = st[`ST_WARN];
                `SEL_OVF:         sel_level = st[`ST_OVF];
                `SEL_REV_LIMIT:   sel_level = st[`ST_REV_LIMIT];
                `SEL_FWD_LIMIT:   sel_level = st[`ST_FWD_LIMIT];
                `SEL_CMD_DONE:    sel_level = st[`ST_CMD_DONE];
                default:          sel_level = 1'b0;
            endcase
        end
    endfunction

    // Millisecond overload accumulator; only unbroken overload is counted.
    always @(posedge clk_i)
    begin
        if (rst_i || !overload_i)
        begin
            tick_cnt  <= 32'h00000000;
            ol_acc_ms <= 32'h00000000;
        end
        else if (tick_cnt == TICK_CYCLES - 1)
        begin
            tick_cnt <= 32'h00000000;
            if (ol_acc_ms != 32'hffffffff)
            begin
                ol_acc_ms <= ol_acc_ms + 32'h00000001;
            end
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    // The fault alarm latches until reset; the warning is a level that ends with the overload.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overload_warn_out    <= 1'b0;
            overload_fault_alarm <= 1'b0;
        end
        else
        begin
            overload_warn_out <= overload_i && (ol_acc_ms > warn_time_threshold);
            if (overload_i && (ol_acc_ms > ol_time_ms))
            begin
                overload_fault_alarm <= 1'b1;
            end
        end
    end

    // Command complete falls at start of a register command and rises when it ends.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_done <= 1'b0;
        end
        else if (pr_cmd_started_i || pr_cmd_busy_i)
        begin
            cmd_done <= 1'b0;
        end
        else if (!pr_cmd_busy_i && live_prev[`ST_CMD_DONE] == 1'b0 && cmd_seen)
        begin
            cmd_done <= 1'b1;
        end
    end

    // Remembers that a command has run since reset, so completion is not claimed before one.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_seen <= 1'b0;
        end
        else if (pr_cmd_started_i || pr_cmd_busy_i)
        begin
            cmd_seen <= 1'b1;
        end
    end

    // Output pins and interrupt, all registered.
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1)
        begin : g_out
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    dig_out_o[g] <= 1'b0;
                end
                else
                begin
                    dig_out_o[g] <= sel_level(out_sel[8*g +: 8], live);
                end
            end
        end
    endgenerate

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overload_fault_alarm_o <= 1'b0;
            irq_o                  <= 1'b0;
            live_prev              <= {`ST_WIDTH{1'b0}};
        end
        else
        begin
            overload_fault_alarm_o <= overload_fault_alarm;
            irq_o                  <= |(irq_status & irq_mask);
            live_prev              <= live;
        end
    end

    // Read multiplexer.
    always @*
    begin
        next_dat = 32'h00000000;
        if (adr_i == `REG_CTRL)
        begin
            next_dat = out_sel;
        end
        else if (adr_i == `REG_OL_TIME)
        begin
            next_dat = ol_time_ms;
        end
        else if (adr_i == `REG_WARN_PCT)
        begin
            next_dat = {24'h000000, warn_pct};
        end
        else if (adr_i == `REG_STATUS)
        begin
            next_dat = {24'h000000, live};
        end
        else if (adr_i == `REG_IRQ_STATUS)
        begin
            next_dat = {24'h000000, irq_status};
        end
        else if (adr_i == `REG_IRQ_MASK)
        begin
            next_dat = {24'h000000, irq_mask};
        end
        else if (adr_i == `REG_OL_ACC)
        begin
            next_dat = ol_acc_ms;
        end
    end

    // Wishbone slave: one wait state, ack for one cycle; unmapped reads return zero.
    integer b;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o      <= 1'b0;
            dat_o      <= 32'h00000000;
            out_sel    <= {NUM_OUT{`RST_SEL}};
            ol_time_ms <= `RST_OL_TIME_MS;
            warn_pct   <= `RST_WARN_PCT;
            irq_mask   <= {`ST_WIDTH{1'b0}};
            irq_status <= {`ST_WIDTH{1'b0}};
        end
        else
        begin
            ack_o <= wb_req;
            dat_o <= wb_req ? next_dat : 32'h00000000;
            // Set wins over a write-one clear in the same cycle.
            if (wb_req && we_i && sel_i[0] && adr_i == `REG_IRQ_STATUS)
            begin
                irq_status <= (irq_status & ~dat_i[`ST_WIDTH-1:0]) | rise;
            end
            else
            begin
                irq_status <= irq_status | rise;
            end
            if (wb_req && we_i)
            begin
                if (adr_i == `REG_CTRL)
                begin
                    for (b = 0; b < 4; b = b + 1)
                    begin
                        if (sel_i[b] && b < NUM_OUT)
                        begin
                            out_sel[8*b +: 8] <= dat_i[8*b +: 8];
                        end
                    end
                end
                else if (adr_i == `REG_OL_TIME)
                begin
                    for (b = 0; b < 4; b = b + 1)
                    begin
                        if (sel_i[b])
                        begin
                            ol_time_ms[8*b +: 8] <= dat_i[8*b +: 8];
                        end
                    end
                end
                else if (adr_i == `REG_WARN_PCT)
                begin
                    if (sel_i[0])
                    begin
                        warn_pct <= dat_i[7:0];
                    end
                end
                else if (adr_i == `REG_IRQ_MASK)
                begin
                    if (sel_i[0])
                    begin
                        irq_mask <= dat_i[`ST_WIDTH-1:0];
                    end
                end
            end
        end
    end

endmodule // servo_status_output_selector
`default_nettype wire

// ==== host_reader_model.sv ====
// Host controller model that samples the drive's digital outputs once per clock.
`timescale 1ns/1ns
`default_nettype none
module host_reader_model (
    // Clock.
    input  wire logic       clk_i,
    // Drive output pins as seen at the host connector.
    input  wire logic [3:0] pins_i,
    // Last sampled levels.
    output var  logic [3:0] seen_o
);
    // A real host registers its inputs, so every level reaches it one clock late.
    always @(posedge clk_i)
        seen_o <= pins_i;
endmodule // host_reader_model
`default_nettype wire

// ==== servo_status_props.sv ====
// Checker for the register bus, reset values and overload alarm of the status selector.
`timescale 1ns/1ns
`default_nettype none
module servo_status_props #(
    parameter TICK_CYCLES = 10,
    parameter NUM_OUT     = 4
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic [31:0]        dat_o,
    input wire logic               ack_o,
    input wire logic               overload_i,
    input wire logic [NUM_OUT-1:0] dig_out_o,
    input wire logic               overload_fault_alarm_o,
    input wire logic               irq_o
);
    logic [31:0] ol_run;
    // Counts clocks of unbroken overload; the alarm may only rise after a full tick of it.
    always @(posedge clk_i)
        if (rst_i || !overload_i)
            ol_run <= 32'h0;
        else
            ol_run <= ol_run + 32'h1;
    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    a_fault_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        overload_fault_alarm_o |=> overload_fault_alarm_o) else $error("alarm released");
    a_fault_continuous: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(overload_fault_alarm_o) |-> $past(ol_run) + 2 >= TICK_CYCLES) else $error("alarm early");
    a_reset_outputs: assert property (@(posedge clk_i)
        rst_i |=> dig_out_o == '0 && !overload_fault_alarm_o) else $error("outputs set in reset");
    a_reset_bus: assert property (@(posedge clk_i)
        rst_i |=> !irq_o && !ack_o) else $error("irq or ack in reset");
    c_alarm: cover property (@(posedge clk_i) $rose(overload_fault_alarm_o));
    c_irq: cover property (@(posedge clk_i) $rose(irq_o));
    c_out: cover property (@(posedge clk_i) $rose(dig_out_o[0]));
endmodule // servo_status_props
bind servo_status_output_selector servo_status_props #(.TICK_CYCLES(TICK_CYCLES), .NUM_OUT(NUM_OUT)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .overload_i(overload_i), .dig_out_o(dig_out_o), .overload_fault_alarm_o(overload_fault_alarm_o),
    .irq_o(irq_o));
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the servo status output selector.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [7:0]  adr_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [11:0] drv;
    logic [3:0]  dig_out_o;
    logic [3:0]  seen;
    logic        alarm;
    logic        irq_o;
    logic [31:0] d;
    int          err_count;
    int          cmp_count;
    logic [7:0]  codes [0:8] = '{8'h07, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h12, 8'h13, 8'h14};
    servo_status_output_selector #(.TICK_CYCLES(10), .NUM_OUT(4)) i_servo_status_output_selector (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .overload_i(drv[9]), .fault_i(drv[0]),
        .rev_limit_err_i(drv[1]), .fwd_limit_err_i(drv[2]), .estop_i(drv[3]), .comm_err_i(drv[4]),
        .undervolt_i(drv[5]), .poscmd_overflow_i(drv[6]), .rev_soft_limit_i(drv[7]),
        .fwd_soft_limit_i(drv[8]), .pr_cmd_busy_i(drv[10]), .pr_cmd_started_i(drv[11]),
        .dig_out_o(dig_out_o), .overload_fault_alarm_o(alarm), .irq_o(irq_o));
    host_reader_model i_host_reader_model (.clk_i(clk_i), .pins_i(dig_out_o), .seen_o(seen));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high, whatever the latency.
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= a;
        dat_i <= wd;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic print_verdict();
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
    initial
    begin
        err_count = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i  = 1'b0;
        adr_i = 8'h00;
        dat_i = 32'h0;
        drv   = 12'h000;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0, d);
        check("selector reset", d, 32'h07070707);
        wb(1'b0, 8'h08, 32'h0, d);
        check("percent reset", d, 32'h0000003c);
        wb(1'b0, 8'h1c, 32'h0, d);
        check("unmapped read", d, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            wb(1'b1, 8'h00, {24'h0, codes[i]}, d);
            drv[i] <= 1'b1;
            settle();
            check("output on", {31'h0, seen[0]}, 32'h1);
            check("unselected outputs", {29'h0, seen[3:1]}, 32'h0);
            drv[i] <= 1'b0;
            settle();
            check("output off", {31'h0, seen[0]}, 32'h0);
        end
        wb(1'b1, 8'h00, 32'h00000015, d);
        settle();
        check("done before command", {31'h0, seen[0]}, 32'h0);
        drv[11:10] <= 2'b11;
        @(posedge clk_i);
        drv[11] <= 1'b0;
        settle();
        check("done while busy", {31'h0, seen[0]}, 32'h0);
        drv[10] <= 1'b0;
        settle();
        check("done after busy", {31'h0, seen[0]}, 32'h1);
        wb(1'b1, 8'h14, 32'h0, d);
        drv[6] <= 1'b1;
        settle();
        drv[6] <= 1'b0;
        settle();
        check("irq masked", {31'h0, irq_o}, 32'h0);
        wb(1'b0, 8'h10, 32'h0, d);
        check("sticky overflow", d & 32'h10, 32'h10);
        wb(1'b1, 8'h14, 32'h10, d);
        settle();
        check("irq raised", {31'h0, irq_o}, 32'h1);
        wb(1'b1, 8'h10, 32'h10, d);
        settle();
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        // Ten ms of allowed overload at sixty percent puts the warning above six ms.
        wb(1'b1, 8'h04, 32'h0000000a, d);
        wb(1'b1, 8'h00, 32'h15120710, d);
        drv[9] <= 1'b1;
        repeat (50) @(posedge clk_i);
        drv[9] <= 1'b0;
        repeat (3) @(posedge clk_i);
        drv[9] <= 1'b1;
        repeat (50) @(posedge clk_i);
        check("warn after break", {31'h0, seen[0]}, 32'h0);
        repeat (40) @(posedge clk_i);
        check("warn at nine ms", {31'h0, seen[0]}, 32'h1);
        check("alarm at nine ms", {31'h0, alarm}, 32'h0);
        check("outputs two and three", {30'h0, seen[3:2]}, 32'h2);
        repeat (40) @(posedge clk_i);
        check("alarm late", {31'h0, alarm}, 32'h1);
        check("servo fault", {31'h0, seen[1]}, 32'h1);
        drv[9] <= 1'b0;
        settle();
        check("warn released", {31'h0, seen[0]}, 32'h0);
        wb(1'b0, 8'h0c, 32'h0, d);
        check("live status", d, 32'h00000086);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
